// *** hdl/pod_pkg.sv ***
/*
  Constants shared by the PWM output-disable block: register offsets,
  field positions, reset values and widths.
  Assumes a 32-bit APB master and one system clock.
*/
`default_nettype none

package pod_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_GROUPS = 4;
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int SET_W      = 8;
  localparam int FLAG_W     = 4;
  localparam int SEL_W      = 2;
  localparam int IRQ_W      = 5;
  localparam int PIN_W      = 6;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_GROUP_A    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_GROUP_B    = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_GROUP_C    = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_GROUP_D    = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_CH0_SEL    = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_PIN_STATE  = 12'h01C;
  localparam logic [ADDR_W-1:0] GROUP_SPAN     = 12'h010;

  // ==========================================================
  // group setting register fields
  localparam int BIT_TRIP    = 0;
  localparam int BIT_REQ     = 1;
  localparam int BIT_OSC     = 2;
  localparam int BIT_SWSTOP  = 3;
  localparam int BIT_TRIP_EN = 4;
  localparam int BIT_REQ_EN  = 5;
  localparam logic [SET_W-1:0] SET_RESET = 8'h00;

  // ==========================================================
  // interrupt status / mask, pin state fields
  localparam int IRQ_OSC_BIT  = 4;
  localparam int PIN_OSC_BIT  = 4;
  localparam int PIN_OFF_BIT  = 5;
  localparam logic [IRQ_W-1:0]  IRQ_RESET  = 5'h00;
  localparam logic [IRQ_W-1:0]  MASK_RESET = 5'h00;
  localparam logic [SEL_W-1:0]  SEL_RESET  = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

endpackage : pod_pkg

`default_nettype wire

// *** hdl/pod_sync.sv ***
/*
  Three-stage synchroniser for pin-level inputs.
  Assumes inputs are asynchronous to sys_clk; the output level only
  changes once the second and third stage agree.
*/
`timescale 1ns/1ns
`default_nettype none

module pod_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,    // system clock
  input  wire logic         rst,        // async reset, high
  input  wire logic [W-1:0] asyncIn,    // raw pin levels
  output logic      [W-1:0] syncLevel   // filtered level
);

  logic [W-1:0] st1_q, st2_q, st3_q, level_q;
  logic [W-1:0] level_d;

  // ==========================================================
  // agreement filter
  always_comb
  begin
    level_d = level_q;
    for (int i = 0; i < W; i++)
    begin
      if (st2_q[i] == st3_q[i])
        level_d[i] = st3_q[i];
    end
  end

  // first stage is read by the second stage only
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st1_q   <= '0;
      st2_q   <= '0;
      st3_q   <= '0;
      level_q <= '0;
    end
    else
    begin
      st1_q   <= asyncIn;
      st2_q   <= st1_q;
      st3_q   <= st2_q;
      level_q <= level_d;
    end
  end

  assign syncLevel = level_q;

endmodule // pod_sync

`default_nettype wire

// *** hdl/pod_group.sv ***
/*
  One output-disable group: setting register with three sticky detection
  flags, a software stop bit and two cause enables.
  Assumes synchronised trip and oscillator levels and a same-clock
  disable request input.
*/
`timescale 1ns/1ns
`default_nettype none

module pod_group (
  input  wire logic                       sys_clk,     // system clock
  input  wire logic                       rst,         // async reset, high
  input  wire logic                       tripLevel,   // synced trip input
  input  wire logic                       reqIn,       // timer/comparator request
  input  wire logic                       oscLevel,    // synced oscillator stop
  input  wire logic                       wrEn,        // register write strobe
  input  wire logic [pod_pkg::SET_W-1:0]  wrData,      // write data
  output logic      [pod_pkg::SET_W-1:0]  setting,     // register value
  output logic                            outOff,      // group disables outputs
  output logic                            tripEvent    // trip flag set pulse
);

  logic                        tripPrev_q, tripPrev_d;
  logic [pod_pkg::FLAG_W-1:0]  flags_q, flags_d;
  logic                        trEn_q, trEn_d, rqEn_q, rqEn_d;
  logic                        tripRise, setTrip, setReq;
  logic [pod_pkg::FLAG_W-1:0]  clrFlag;

  // ==========================================================
  // flag update, set wins over a clearing write
  always_comb
  begin
    tripPrev_d = tripLevel;
    tripRise   = tripLevel & ~tripPrev_q;
    setTrip    = tripRise & trEn_q;
    setReq     = reqIn & rqEn_q;
    clrFlag    = wrEn ? ~wrData[pod_pkg::FLAG_W-1:0] : '0;
    flags_d[pod_pkg::BIT_TRIP] = setTrip | (flags_q[pod_pkg::BIT_TRIP]
                                 & ~clrFlag[pod_pkg::BIT_TRIP]);
    flags_d[pod_pkg::BIT_REQ]  = setReq | (flags_q[pod_pkg::BIT_REQ]
                                 & ~clrFlag[pod_pkg::BIT_REQ]);
    flags_d[pod_pkg::BIT_OSC]  = oscLevel | (flags_q[pod_pkg::BIT_OSC]
                                 & ~clrFlag[pod_pkg::BIT_OSC]);
    // software stop is written directly
    flags_d[pod_pkg::BIT_SWSTOP] = wrEn ? wrData[pod_pkg::BIT_SWSTOP]
                                        : flags_q[pod_pkg::BIT_SWSTOP];
    trEn_d = wrEn ? wrData[pod_pkg::BIT_TRIP_EN] : trEn_q;
    rqEn_d = wrEn ? wrData[pod_pkg::BIT_REQ_EN]  : rqEn_q;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tripPrev_q <= 1'b0;
      flags_q    <= pod_pkg::SET_RESET[pod_pkg::FLAG_W-1:0];
      trEn_q     <= pod_pkg::SET_RESET[pod_pkg::BIT_TRIP_EN];
      rqEn_q     <= pod_pkg::SET_RESET[pod_pkg::BIT_REQ_EN];
    end
    else
    begin
      tripPrev_q <= tripPrev_d;
      flags_q    <= flags_d;
      trEn_q     <= trEn_d;
      rqEn_q     <= rqEn_d;
    end
  end

  assign setting   = {2'b00, rqEn_q, trEn_q, flags_q};
  assign outOff    = |flags_q;
  assign tripEvent = setTrip;

  // ==========================================================
  // checks
  chk_trip_sets_flag:
    assert property (@(posedge sys_clk) disable iff (rst)
      (tripLevel && !tripPrev_q && trEn_q) |=> flags_q[pod_pkg::BIT_TRIP])
    else $error("trip edge did not set trip flag");

  chk_flag_holds:
    assert property (@(posedge sys_clk) disable iff (rst)
      (outOff && !wrEn) |=> outOff)
    else $error("disable released without a clearing write");

  chk_req_flag:
    assert property (@(posedge sys_clk) disable iff (rst)
      (reqIn && rqEn_q) |=> flags_q[pod_pkg::BIT_REQ] ##0 outOff)
    else $error("disable request did not set its flag");

  chk_release_clear:
    assert property (@(posedge sys_clk) disable iff (rst)
      (wrEn && wrData[pod_pkg::FLAG_W-1:0] == '0 && !oscLevel && !reqIn
       && !tripLevel) |=> !outOff)
    else $error("clearing all flags did not release the group");

endmodule // pod_group

`default_nettype wire

// *** hdl/pod_top.sv ***
/*
  PWM output-disable block: four disable groups, channel 0 pin gating,
  per-group and oscillator-stop interrupts, APB register slave.
  Assumes one 125 MHz system clock; trip pins and the oscillator-stop
  level are asynchronous, timer and comparator requests are on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module pod_top (
  input  wire logic                         sys_clk,          // 125 MHz clock
  input  wire logic                         rst,              // async reset, high
  input  wire logic                         psel,             // APB select
  input  wire logic                         penable,          // APB enable
  input  wire logic                         pwrite,           // APB direction
  input  wire logic [pod_pkg::ADDR_W-1:0]   paddr,            // APB byte address
  input  wire logic [pod_pkg::DATA_W-1:0]   pwdata,           // APB write data
  output logic      [pod_pkg::DATA_W-1:0]   prdata,           // APB read data
  output logic                              pready,           // APB ready
  output logic                              pslverr,          // APB error
  input  wire logic [pod_pkg::NUM_GROUPS-1:0] externalTripInput, // trip pins A..D
  input  wire logic [pod_pkg::NUM_GROUPS-1:0] pwmTimerReq,    // timer disable requests
  input  wire logic [pod_pkg::NUM_GROUPS-1:0] fastCompIrq,    // comparator interrupts
  input  wire logic                         oscStopIn,        // clock monitor stop level
  input  wire logic                         timerOutA,        // timer channel 0 A value
  input  wire logic                         timerOutB,        // timer channel 0 B value
  input  wire logic                         timerOeA,         // timer channel 0 A enable
  input  wire logic                         timerOeB,         // timer channel 0 B enable
  output logic                              timer0OutputA,    // pin A output
  output logic                              timer0OutputAOe,  // pin A drive enable
  output logic                              timer0OutputB,    // pin B output
  output logic                              timer0OutputBOe,  // pin B drive enable
  output logic [pod_pkg::NUM_GROUPS-1:0]    groupIrq,         // per-group event requests
  output logic                              nmiReq,           // oscillator-stop NMI
  output logic                              irq               // masked combined interrupt
);

  localparam int NG = pod_pkg::NUM_GROUPS;

  // ==========================================================
  // input synchronisers
  logic [NG-1:0] tripSync;
  logic [0:0]    oscSync;
  logic          oscPrev_q, oscPrev_d, oscRise;

  pod_sync #(.W(NG)) u_trip_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .asyncIn   (externalTripInput),
    .syncLevel (tripSync)
  );

  pod_sync #(.W(1)) u_osc_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .asyncIn   (oscStopIn),
    .syncLevel (oscSync)
  );

  // ==========================================================
  // APB decode
  logic                       setupPh, accessPh, wrAcc;
  logic                       addrOk, grpHit;
  logic [pod_pkg::SEL_W-1:0]  grpIdx;
  logic [NG-1:0]              grpWr;

  always_comb
  begin
    setupPh  = psel & ~penable;
    accessPh = psel & penable;
    wrAcc    = accessPh & pwrite;
    grpHit   = (paddr < pod_pkg::GROUP_SPAN) && (paddr[1:0] == 2'b00);
    grpIdx   = paddr[3:2];
    addrOk   = grpHit
             || paddr == pod_pkg::OFF_CH0_SEL
             || paddr == pod_pkg::OFF_IRQ_STATUS
             || paddr == pod_pkg::OFF_IRQ_MASK
             || paddr == pod_pkg::OFF_PIN_STATE;
    grpWr = '0;
    if (wrAcc && grpHit)
      grpWr[grpIdx] = 1'b1;
  end

  // zero-wait slave; unmapped or misaligned addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~addrOk;

  // ==========================================================
  // groups A..D
  logic [pod_pkg::SET_W-1:0] grpSetting [NG];
  logic [NG-1:0]             grpOff;
  logic [NG-1:0]             tripEvt;
  logic [NG-1:0]             reqCause;

  // both the timer and the comparator feed the request flag
  assign reqCause = pwmTimerReq | fastCompIrq;

  genvar g;
  generate
    for (g = 0; g < NG; g++)
    begin : gen_group
      pod_group u_group (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .tripLevel (tripSync[g]),
        .reqIn     (reqCause[g]),
        .oscLevel  (oscSync[0]),
        .wrEn      (grpWr[g]),
        .wrData    (pwdata[pod_pkg::SET_W-1:0]),
        .setting   (grpSetting[g]),
        .outOff    (grpOff[g]),
        .tripEvent (tripEvt[g])
      );
    end
  endgenerate

  // ==========================================================
  // control and interrupt registers
  logic [pod_pkg::SEL_W-1:0] ch0Sel_q, ch0Sel_d;
  logic [pod_pkg::IRQ_W-1:0] status_q, status_d;
  logic [pod_pkg::IRQ_W-1:0] mask_q, mask_d;
  logic [pod_pkg::IRQ_W-1:0] statusSet, statusClr;
  logic                      irq_q, irq_d;

  always_comb
  begin
    oscPrev_d = oscSync[0];
    oscRise   = oscSync[0] & ~oscPrev_q;
    ch0Sel_d  = ch0Sel_q;
    mask_d    = mask_q;
    statusClr = '0;
    if (wrAcc && paddr == pod_pkg::OFF_CH0_SEL)
      ch0Sel_d = pwdata[pod_pkg::SEL_W-1:0];
    if (wrAcc && paddr == pod_pkg::OFF_IRQ_MASK)
      mask_d = pwdata[pod_pkg::IRQ_W-1:0];
    if (wrAcc && paddr == pod_pkg::OFF_IRQ_STATUS)
      statusClr = pwdata[pod_pkg::IRQ_W-1:0];
    // event n belongs to group n for n 0..3, bit 4 is the oscillator stop; a new event beats a same-cycle clear
    statusSet = {oscRise, tripEvt};
    status_d  = statusSet | (status_q & ~statusClr);
    irq_d     = |(status_d & mask_d);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      oscPrev_q <= 1'b0;
      ch0Sel_q  <= pod_pkg::SEL_RESET;
      mask_q    <= pod_pkg::MASK_RESET;
      status_q  <= pod_pkg::IRQ_RESET;
      irq_q     <= 1'b0;
    end
    else
    begin
      oscPrev_q <= oscPrev_d;
      ch0Sel_q  <= ch0Sel_d;
      mask_q    <= mask_d;
      status_q  <= status_d;
      irq_q     <= irq_d;
    end
  end

  assign groupIrq = status_q[NG-1:0];
  // the NMI ignores the mask on purpose: a dead clock must not be hidden
  assign nmiReq   = status_q[pod_pkg::IRQ_OSC_BIT];
  assign irq      = irq_q;

  // ==========================================================
  // channel 0 pin gating
  logic ch0Off;
  logic outA_q, outA_d, outB_q, outB_d;
  logic oeA_q, oeA_d, oeB_q, oeB_d;

  always_comb
  begin
    // oscillator flag lives in every group, so the selected one sees it
    ch0Off = grpOff[ch0Sel_q];
    outA_d = timerOutA;
    outB_d = timerOutB;
    // high impedance held while any flag of the group stays set
    oeA_d  = timerOeA & ~ch0Off;
    oeB_d  = timerOeB & ~ch0Off;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      outA_q <= 1'b0;
      outB_q <= 1'b0;
      oeA_q  <= 1'b0;
      oeB_q  <= 1'b0;
    end
    else
    begin
      outA_q <= outA_d;
      outB_q <= outB_d;
      oeA_q  <= oeA_d;
      oeB_q  <= oeB_d;
    end
  end

  assign timer0OutputA   = outA_q;
  assign timer0OutputB   = outB_q;
  assign timer0OutputAOe = oeA_q;
  assign timer0OutputBOe = oeB_q;

  // ==========================================================
  // read path: data captured in the setup cycle
  logic [pod_pkg::DATA_W-1:0] rdata_q, rdata_d, rdMux;
  logic [pod_pkg::PIN_W-1:0]  pinState;

  assign pinState = {ch0Off, oscSync[0], tripSync};

  always_comb
  begin
    rdMux = pod_pkg::RDATA_ZERO;
    if (grpHit)
      rdMux[pod_pkg::SET_W-1:0] = grpSetting[grpIdx];
    else if (paddr == pod_pkg::OFF_CH0_SEL)
      rdMux[pod_pkg::SEL_W-1:0] = ch0Sel_q;
    else if (paddr == pod_pkg::OFF_IRQ_STATUS)
      rdMux[pod_pkg::IRQ_W-1:0] = status_q;
    else if (paddr == pod_pkg::OFF_IRQ_MASK)
      rdMux[pod_pkg::IRQ_W-1:0] = mask_q;
    else if (paddr == pod_pkg::OFF_PIN_STATE)
      rdMux[pod_pkg::PIN_W-1:0] = pinState;
    rdata_d = (setupPh && !pwrite) ? rdMux : rdata_q;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= pod_pkg::RDATA_ZERO;
    else
      rdata_q <= rdata_d;
  end

  assign prdata = rdata_q;

  // ==========================================================
  // checks
  chk_trip_hiz_pins:
    assert property (@(posedge sys_clk) disable iff (rst)
      grpOff[ch0Sel_q] |=> (!timer0OutputAOe && !timer0OutputBOe))
    else $error("channel 0 pins driven while its group is disabled");

  chk_group_event:
    assert property (@(posedge sys_clk) disable iff (rst)
      tripEvt[0] |=> (groupIrq[0] && grpSetting[0][pod_pkg::BIT_TRIP]))
    else $error("group A trip did not raise its event");

  chk_event_order:
    assert property (@(posedge sys_clk) disable iff (rst)
      (|tripEvt) |=> ((groupIrq & $past(tripEvt)) == $past(tripEvt)))
    else $error("trip event landed on the wrong group request");

  chk_osc_nmi:
    assert property (@(posedge sys_clk) disable iff (rst)
      oscRise |=> nmiReq ##1 (!timer0OutputAOe && !timer0OutputBOe))
    else $error("oscillator stop missed the NMI or the pin float");

  chk_group_read:
    assert property (@(posedge sys_clk) disable iff (rst)
      (setupPh && !pwrite && grpHit)
        |=> prdata[pod_pkg::SET_W-1:0] == $past(grpSetting[grpIdx]))
    else $error("group setting read returned the wrong value");

  chk_comp_cause:
    assert property (@(posedge sys_clk) disable iff (rst)
      (fastCompIrq[ch0Sel_q] && grpSetting[ch0Sel_q][pod_pkg::BIT_REQ_EN]
       && !(wrAcc && paddr == pod_pkg::OFF_CH0_SEL)
       && $stable(ch0Sel_q)) |=> ##1 !timer0OutputAOe)
    else $error("comparator cause did not disable channel 0");

  chk_release_pins:
    assert property (@(posedge sys_clk) disable iff (rst)
      (!grpOff[ch0Sel_q] && timerOeA && $stable(ch0Sel_q)) |=> timer0OutputAOe)
    else $error("pin not released after flags were cleared");

  chk_unmapped_err:
    assert property (@(posedge sys_clk) disable iff (rst)
      (accessPh && paddr > pod_pkg::OFF_PIN_STATE) |-> pslverr)
    else $error("unmapped address answered without error");

  chk_irq_level:
    assert property (@(posedge sys_clk) disable iff (rst)
      irq == (|(status_q & mask_q)))
    else $error("interrupt output disagrees with masked status");

  chk_nmi_sticky:
    assert property (@(posedge sys_clk) disable iff (rst)
      (nmiReq && !(wrAcc && paddr == pod_pkg::OFF_IRQ_STATUS)) |=> nmiReq)
    else $error("NMI request dropped without a clearing write");

  chk_nmi_clear:
    assert property (@(posedge sys_clk) disable iff (rst)
      (wrAcc && paddr == pod_pkg::OFF_IRQ_STATUS && pwdata[pod_pkg::IRQ_OSC_BIT]
       && !oscRise) |=> !nmiReq)
    else $error("NMI request survived its clearing write");

  chk_status_w1c:
    assert property (@(posedge sys_clk) disable iff (rst)
      (wrAcc && paddr == pod_pkg::OFF_IRQ_STATUS && pwdata[0] && !tripEvt[0])
        |=> !groupIrq[0])
    else $error("group A event survived its clearing write");

  chk_pin_copy:
    assert property (@(posedge sys_clk) disable iff (rst)
      1'b1 |=> (timer0OutputA == $past(timerOutA) && timer0OutputB == $past(timerOutB)))
    else $error("channel 0 pin values are not a one-cycle copy");

  chk_unmapped_zero:
    assert property (@(posedge sys_clk) disable iff (rst)
      (accessPh && !pwrite && !addrOk && $past(setupPh)) |-> prdata == pod_pkg::RDATA_ZERO)
    else $error("unmapped read returned data");

  chk_refused_write:
    assert property (@(posedge sys_clk) disable iff (rst)
      (wrAcc && !addrOk) |=> (mask_q == $past(mask_q) && ch0Sel_q == $past(ch0Sel_q)))
    else $error("refused write changed a register");

  chk_mask_write:
    assert property (@(posedge sys_clk) disable iff (rst)
      (wrAcc && paddr == pod_pkg::OFF_IRQ_MASK)
        |=> mask_q == $past(pwdata[pod_pkg::IRQ_W-1:0]))
    else $error("mask write did not land");

  chk_sel_write:
    assert property (@(posedge sys_clk) disable iff (rst)
      (wrAcc && paddr == pod_pkg::OFF_CH0_SEL)
        |=> ch0Sel_q == $past(pwdata[pod_pkg::SEL_W-1:0]))
    else $error("group select write did not land");

endmodule // pod_top

`default_nettype wire

// *** tb/pod_far_side.sv ***
/*
  Far-side model: four trip pins and the channel 0 timer waveform.
  Assumes tripCmd pulses for one sys_clk cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module pod_far_side (
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rst,       // async reset, high
  input  wire logic [3:0] tripCmd,   // fire trip pin n
  input  wire logic       oeA,       // block drive enable A
  input  wire logic       outA,      // block pin A value
  output logic      [3:0] tripPin,   // trip pins, pulled low
  output logic            timerOut,  // channel 0 waveform
  output wire             padA       // resolved pin A level
);
  // ==========================================================
  // trip pulses
  logic [2:0] holdQ [4];

  // six cycles high so the synchroniser always sees the edge
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int g = 0; g < 4; g++)
        holdQ[g] <= 3'h0;
    end
    else
    begin
      for (int g = 0; g < 4; g++)
        if (tripCmd[g])
          holdQ[g] <= 3'h6;
        else if (holdQ[g] != 3'h0)
          holdQ[g] <= holdQ[g] - 3'h1;
    end
  end

  always_comb
    for (int g = 0; g < 4; g++)
      tripPin[g] = (holdQ[g] != 3'h0);

  // ==========================================================
  // timer waveform and pin
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      timerOut <= 1'b0;
    else
      timerOut <= ~timerOut;

  assign padA = oeA ? outA : 1'bz;
endmodule // pod_far_side

`default_nettype wire

// *** tb/pod_top_test.sv ***
/*
  Self-checking bench for the output-disable block.
  Assumes zero-wait APB and the far-side model beside it.
*/
`timescale 1ns/1ns
`default_nettype none

module pod_top_test;
  logic        sys_clk, rst, psel, penable, pwrite, oscStopIn, oeIn, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic        pready, pslverr, timerOut, nmiReq, irq, outA, outB, oeA, oeB;
  logic [3:0]  tripCmd, tripPin, pwmTimerReq, fastCompIrq, groupIrq;
  wire         padA;
  int          n_errors = 0;
  int          compares = 0;

  pod_top i_pod_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalTripInput(tripPin), .pwmTimerReq(pwmTimerReq),
    .fastCompIrq(fastCompIrq), .oscStopIn(oscStopIn), .timerOutA(timerOut),
    .timerOutB(~timerOut), .timerOeA(oeIn), .timerOeB(oeIn), .timer0OutputA(outA),
    .timer0OutputAOe(oeA), .timer0OutputB(outB), .timer0OutputBOe(oeB),
    .groupIrq(groupIrq), .nmiReq(nmiReq), .irq(irq));

  pod_far_side i_pod_far_side (.sys_clk(sys_clk), .rst(rst), .tripCmd(tripCmd),
    .oeA(oeA), .outA(outA), .tripPin(tripPin), .timerOut(timerOut), .padA(padA));

  always #4 sys_clk = ~sys_clk;

  // ==========================================================
  // shared tasks
  task automatic results();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // starts one edge later so a release and the next setup never share an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdVal   = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdVal, exp, "read");
  endtask

  // first look is at a negedge so outputs launched by the last edge have settled
  task automatic waitOe(input logic v);
    @(negedge sys_clk);
    for (int i = 0; i < 16 && oeA !== v; i++) @(negedge sys_clk);
    chk(oeA, v, "oe a");
    chk(oeB, v, "oe b");
    chk(padA, v ? outA : 1'bz, "pad a");
    chk(outA, !timerOut, "out a copy");
    chk(outB, timerOut, "out b copy");
  endtask

  task automatic pulse(input int src, input int g);
    @(posedge sys_clk);
    if (src == 0) tripCmd[g] <= 1'b1;
    if (src == 1) pwmTimerReq[g] <= 1'b1;
    if (src == 2) fastCompIrq[g] <= 1'b1;
    @(posedge sys_clk);
    tripCmd     <= 4'h0;
    pwmTimerReq <= 4'h0;
    fastCompIrq <= 4'h0;
  endtask

  // ==========================================================
  // scenarios
  task automatic testReset();
    for (int a = 0; a < 32; a += 4) rd(a[11:0], 32'h0000_0000);
    chk(lastErr, 1'b0, "mapped no error");
    rd(12'h020, 32'h0000_0000);
    chk(lastErr, 1'b1, "unmapped error");
    apb(1'b1, 12'h002, 32'h0000_0008);
    chk(lastErr, 1'b1, "misaligned error");
    waitOe(1'b1);
    $display("reset values done");
  endtask

  task automatic testTrip(input int g);
    apb(1'b1, pod_pkg::OFF_CH0_SEL, g);
    apb(1'b1, g * 4, 32'h0000_0010);
    apb(1'b1, pod_pkg::OFF_IRQ_MASK, 32'h0000_001F);
    pulse(0, g);
    waitOe(1'b0);
    chk(groupIrq, 1 << g, "group event");
    chk(irq, 1'b1, "irq");
    rd(g * 4, 32'h0000_0011);
    repeat (10) @(negedge sys_clk);
    waitOe(1'b0);
    rd(pod_pkg::OFF_IRQ_STATUS, 1 << g);
    apb(1'b1, pod_pkg::OFF_IRQ_STATUS, 1 << g);
    apb(1'b1, g * 4, 32'h0000_0010);
    waitOe(1'b1);
    rd(pod_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
    chk(irq, 1'b0, "irq clear");
    $display("trip group %0d done", g);
  endtask

  task automatic testReq(input int src);
    apb(1'b1, pod_pkg::OFF_CH0_SEL, 32'h0000_0000);
    apb(1'b1, pod_pkg::OFF_GROUP_A, 32'h0000_0020);
    pulse(src, 0);
    waitOe(1'b0);
    rd(pod_pkg::OFF_GROUP_A, 32'h0000_0022);
    chk(groupIrq, 4'h0, "no event");
    apb(1'b1, pod_pkg::OFF_GROUP_A, 32'h0000_0020);
    waitOe(1'b1);
    $display("request source %0d done", src);
  endtask

  task automatic testSoftOsc();
    apb(1'b1, pod_pkg::OFF_CH0_SEL, 32'h0000_0002);
    apb(1'b1, pod_pkg::OFF_GROUP_C, 32'h0000_0008);
    waitOe(1'b0);
    rd(pod_pkg::OFF_GROUP_C, 32'h0000_0008);
    apb(1'b1, pod_pkg::OFF_GROUP_C, 32'h0000_0000);
    waitOe(1'b1);
    apb(1'b1, pod_pkg::OFF_IRQ_MASK, 32'h0000_000F);
    @(posedge sys_clk);
    oscStopIn <= 1'b1;
    waitOe(1'b0);
    @(negedge sys_clk);
    chk(nmiReq, 1'b1, "nmi");
    chk(irq, 1'b0, "nmi bypasses mask");
    rd(pod_pkg::OFF_PIN_STATE, 32'h0000_0030);
    // clear attempt while still stopped: the oscillator flag must win
    apb(1'b1, pod_pkg::OFF_GROUP_C, 32'h0000_0000);
    rd(pod_pkg::OFF_GROUP_C, 32'h0000_0004);
    rd(pod_pkg::OFF_GROUP_D, 32'h0000_0014);
    oscStopIn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    for (int g = 0; g < 4; g++) apb(1'b1, g * 4, 32'h0000_0000);
    apb(1'b1, pod_pkg::OFF_IRQ_STATUS, 32'h0000_0010);
    waitOe(1'b1);
    chk(nmiReq, 1'b0, "nmi clear");
    $display("software and oscillator stop done");
  endtask

  // ==========================================================
  // sequence and watchdog
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, oscStopIn, lastErr} = '0;
    {paddr, pwdata, tripCmd, pwmTimerReq, fastCompIrq} = '0;
    oeIn = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    testReset();
    for (int g = 0; g < 4; g++) testTrip(g);
    for (int s = 1; s < 3; s++) testReq(s);
    testSoftOsc();
    results();
  end

  // the full run needs a few hundred cycles
  initial
  begin
    #(8 * 20000);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule // pod_top_test

`default_nettype wire
